/* File: dblcpm_pkg.sv */
package dblcpm_pkg;

   // direct register addresses of the two line i/o control registers
   localparam logic [15:0] ADDR_IOCTL_CH6 = 16'h7F01;
   localparam logic [15:0] ADDR_IOCTL_CH10 = 16'hBF01;

   // indirect access: page byte then offset byte
   localparam logic [7:0] IND_PAGE_CH6 = 8'h7E;
   localparam logic [7:0] IND_PAGE_CH10 = 8'hBE;
   localparam logic [7:0] IND_OFS_IOCTL = 8'h01;

   // line i/o control fields
   localparam int IOCTL_BIT_INVERT = 0;
   localparam int IOCTL_BIT_CLK_STATE = 7;
   localparam logic [7:0] IOCTL_RESET = 8'h00;
   localparam logic [7:0] IOCTL_RW_MASK = 8'h7F;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // drop bus geometry
   localparam int DROP_W = 8;
   localparam int DROP_BIT_SHARED_CH6 = 6;
   localparam int DROP_BIT_SHARED_CH10 = 7;
   localparam logic [DROP_W-1:0] DROP_RESET = 8'h00;

   // channel slots in the per-channel vectors
   localparam int SLOT_CH6 = 0;
   localparam int SLOT_CH10 = 1;
   localparam int NUM_LINE_CH = 2;

   // external clock inputs sampled by the core clock
   localparam int EXT_DROP_CLK = 0;
   localparam int EXT_LINE_CH6 = 1;
   localparam int EXT_LINE_CH10 = 2;
   localparam int NUM_EXT = 3;

   // timing: core clock and the fastest expected link clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_PERIOD_NS = 160;
   localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;

   // buffer depth
   localparam int BUF_DEPTH = 2;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic indirect;
   } dblcpm_up_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic ack;
   } dblcpm_up_rsp_t;

endpackage : dblcpm_pkg

/* File: dblcpm_buf.sv */
`timescale 1ns/1ps

// two-entry buffer; full and empty are exact, so a stalled sink fills it
module dblcpm_buf #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // fill side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   logic [W-1:0] mem_r [2];
   logic wptr_r;
   logic rptr_r;
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   logic in_ready_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // ready is registered so the fill-side ready leaves the block from a flop
   assign in_ready = in_ready_r;
   assign out_valid = (count_r != 2'h0);
   assign out_data = mem_r[rptr_r];
   assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         count_r <= 2'h0;
         in_ready_r <= 1'b1;
      end else begin
         count_r <= count_nxt;
         in_ready_r <= (count_nxt != 2'h2);
         if (push) wptr_r <= ~wptr_r;
         if (pop) rptr_r <= ~rptr_r;
      end
   end

   always_ff @(posedge clock) begin
      if (push) mem_r[wptr_r] <= in_data;
   end

endmodule : dblcpm_buf

/* File: dblcpm_top.sv */
`timescale 1ns/1ps

// Function
// RULE1 - pin6 carries drop bit6 or ch6 clock
// RULE2 - pin7 carries drop bit7 or ch10 clock
// RULE3 - drop bus updates on drop clock rise
// RULE4 - drop bus eight bits, bit7 msb
// RULE5 - line mode outputs ds3/e3/sts-1 rate clock
// RULE6 - line data updates on clock rise by default
// RULE7 - ch6 invert bit selects falling-edge update
// RULE8 - ch10 invert bit selects falling-edge update
// RULE9 - sts-1 mode ignores invert, always rising
// RULE10 - control registers reachable direct and indirect
// RULE11 - invert bit resets to zero
module dblcpm_top (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // microprocessor register port
   input wire dblcpm_pkg::dblcpm_up_req_t up_req,
   output dblcpm_pkg::dblcpm_up_rsp_t up_rsp,
   // mode controls from the framer configuration
   input wire logic tbus_ch2_enable,
   input wire logic sts1_mode_ch6,
   input wire logic sts1_mode_ch10,
   // drop word stream from the telecom bus core
   input wire logic [7:0] drop_word_data,
   input wire logic drop_word_valid,
   output logic drop_word_ready,
   // clocks arriving from outside the core domain
   input wire logic drop_bus_ch2_clock,
   input wire logic line_rate_clock_ch6,
   input wire logic line_rate_clock_ch10,
   // serial line data from the framers
   input wire logic line_tx_bit_ch6,
   input wire logic line_tx_bit_ch10,
   // pins
   output logic [5:0] drop_bus_ch2_bits5_0,
   output logic drop_bus_ch2_bit6,
   output logic drop_bus_ch2_bit7,
   output logic line_data_out_ch6,
   output logic line_data_out_ch10
);

   // external clock sampling
   logic [dblcpm_pkg::NUM_EXT-1:0] ext_raw;
   logic [dblcpm_pkg::NUM_EXT-1:0] sync1_r;
   logic [dblcpm_pkg::NUM_EXT-1:0] sync2_r;
   logic [dblcpm_pkg::NUM_EXT-1:0] sync3_r;
   logic [dblcpm_pkg::NUM_EXT-1:0] level_r;
   logic [dblcpm_pkg::NUM_EXT-1:0] level_nxt;
   logic [dblcpm_pkg::NUM_EXT-1:0] level_d_r;
   logic [dblcpm_pkg::NUM_EXT-1:0] rise;
   logic [dblcpm_pkg::NUM_EXT-1:0] fall;

   assign ext_raw[dblcpm_pkg::EXT_DROP_CLK] = drop_bus_ch2_clock;
   assign ext_raw[dblcpm_pkg::EXT_LINE_CH6] = line_rate_clock_ch6;
   assign ext_raw[dblcpm_pkg::EXT_LINE_CH10] = line_rate_clock_ch10;

   // a level change is accepted only once stages two and three agree
   assign level_nxt = (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r));
   assign rise = level_r & ~level_d_r;
   assign fall = ~level_r & level_d_r;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= ext_raw;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         level_r <= '0;
         level_d_r <= '0;
      end else begin
         level_r <= level_nxt;
         level_d_r <= level_r;
      end
   end

   // register port decode
   logic [7:0] ioctl_r [dblcpm_pkg::NUM_LINE_CH];
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic ack_r;

   wire [7:0] up_page = up_req.addr[15:8];
   wire [7:0] up_ofs = up_req.addr[7:0];
   wire direct_ch6 = !up_req.indirect && (up_req.addr == dblcpm_pkg::ADDR_IOCTL_CH6);
   wire direct_ch10 = !up_req.indirect && (up_req.addr == dblcpm_pkg::ADDR_IOCTL_CH10);
   wire ind_ch6 = up_req.indirect && (up_page == dblcpm_pkg::IND_PAGE_CH6)
                  && (up_ofs == dblcpm_pkg::IND_OFS_IOCTL);
   wire ind_ch10 = up_req.indirect && (up_page == dblcpm_pkg::IND_PAGE_CH10)
                   && (up_ofs == dblcpm_pkg::IND_OFS_IOCTL);
   wire hit_ch6 = direct_ch6 || ind_ch6; // [RULE10]
   wire hit_ch10 = direct_ch10 || ind_ch10; // [RULE10]
   wire [dblcpm_pkg::NUM_LINE_CH-1:0] hit = {hit_ch10, hit_ch6};
   wire [dblcpm_pkg::NUM_LINE_CH-1:0] wr_hit = hit & {2{up_req.wr}};
   wire strobe = up_req.wr || up_req.rd;

   // bit 7 reads back the live line clock level; it cannot be written
   wire [7:0] rd_view_ch6 = {level_r[dblcpm_pkg::EXT_LINE_CH6],
                             ioctl_r[dblcpm_pkg::SLOT_CH6][6:0]};
   wire [7:0] rd_view_ch10 = {level_r[dblcpm_pkg::EXT_LINE_CH10],
                              ioctl_r[dblcpm_pkg::SLOT_CH10][6:0]};

   assign rdata_nxt = !up_req.rd ? rdata_r :
                      hit_ch6 ? rd_view_ch6 :
                      hit_ch10 ? rd_view_ch10 :
                      dblcpm_pkg::RDATA_UNMAPPED;

   genvar g;
   generate
      for (g = 0; g < dblcpm_pkg::NUM_LINE_CH; g++) begin : g_ioctl
         always_ff @(posedge clock) begin
            if (!rstn) begin
               ioctl_r[g] <= dblcpm_pkg::IOCTL_RESET; // [RULE11]
            end else if (wr_hit[g]) begin
               ioctl_r[g] <= up_req.wdata & dblcpm_pkg::IOCTL_RW_MASK;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdata_r <= dblcpm_pkg::RDATA_UNMAPPED;
         ack_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ack_r <= strobe;
      end
   end

   assign up_rsp = '{rdata: rdata_r, ack: ack_r};

   // drop bus path
   logic [7:0] buf_data;
   logic buf_valid;
   logic buf_pop;
   logic [dblcpm_pkg::DROP_W-1:0] drop_r;

   // the buffer absorbs words while the slow drop clock has not yet ticked
   dblcpm_buf #(
      .W(dblcpm_pkg::DROP_W)
   ) u_buf (
      .clock(clock),
      .rstn(rstn),
      .in_data(drop_word_data),
      .in_valid(drop_word_valid),
      .in_ready(drop_word_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_pop)
   );

   wire drop_tick = rise[dblcpm_pkg::EXT_DROP_CLK] && tbus_ch2_enable;
   assign buf_pop = drop_tick; // [RULE3]

   // without a word the bus holds its last value rather than glitching
   always_ff @(posedge clock) begin
      if (!rstn) begin
         drop_r <= dblcpm_pkg::DROP_RESET;
      end else if (drop_tick && buf_valid) begin
         drop_r <= buf_data; // [RULE3] [RULE4]
      end
   end

   // line data edge selection
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] sts1_mode;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] invert_bit;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] use_fall;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] line_rise;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] line_fall;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] line_upd;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] line_bit;
   logic [dblcpm_pkg::NUM_LINE_CH-1:0] line_out_r;

   assign sts1_mode = {sts1_mode_ch10, sts1_mode_ch6};
   assign line_bit = {line_tx_bit_ch10, line_tx_bit_ch6};
   assign invert_bit[dblcpm_pkg::SLOT_CH6] =
      ioctl_r[dblcpm_pkg::SLOT_CH6][dblcpm_pkg::IOCTL_BIT_INVERT]; // [RULE7]
   assign invert_bit[dblcpm_pkg::SLOT_CH10] =
      ioctl_r[dblcpm_pkg::SLOT_CH10][dblcpm_pkg::IOCTL_BIT_INVERT]; // [RULE8]
   assign line_rise = {rise[dblcpm_pkg::EXT_LINE_CH10], rise[dblcpm_pkg::EXT_LINE_CH6]};
   assign line_fall = {fall[dblcpm_pkg::EXT_LINE_CH10], fall[dblcpm_pkg::EXT_LINE_CH6]};

   // sts-1 forces the rising edge whatever the invert bit holds
   assign use_fall = invert_bit & ~sts1_mode; // [RULE7] [RULE8] [RULE9]
   assign line_upd = (use_fall & line_fall) | (~use_fall & line_rise); // [RULE6]

   generate
      for (g = 0; g < dblcpm_pkg::NUM_LINE_CH; g++) begin : g_line
         always_ff @(posedge clock) begin
            if (!rstn) begin
               line_out_r[g] <= 1'b0;
            end else if (line_upd[g]) begin
               line_out_r[g] <= line_bit[g]; // [RULE6]
            end
         end
      end
   endgenerate

   // shared pin selection
   logic pin6_r;
   logic pin7_r;
   logic [5:0] drop_lo_r;
   logic data6_r;
   logic data10_r;

   // line clock copies the filtered rate clock; one core cycle of jitter
   wire pin6_nxt = tbus_ch2_enable ? drop_r[dblcpm_pkg::DROP_BIT_SHARED_CH6]
                                   : level_r[dblcpm_pkg::EXT_LINE_CH6]; // [RULE1] [RULE5]
   wire pin7_nxt = tbus_ch2_enable ? drop_r[dblcpm_pkg::DROP_BIT_SHARED_CH10]
                                   : level_r[dblcpm_pkg::EXT_LINE_CH10]; // [RULE2] [RULE5]

   // data leaves one core cycle after the pin edge, well inside half a line period
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pin6_r <= 1'b0;
         pin7_r <= 1'b0;
         drop_lo_r <= '0;
         data6_r <= 1'b0;
         data10_r <= 1'b0;
      end else begin
         pin6_r <= pin6_nxt;
         pin7_r <= pin7_nxt;
         drop_lo_r <= drop_r[5:0]; // [RULE4]
         data6_r <= line_out_r[dblcpm_pkg::SLOT_CH6];
         data10_r <= line_out_r[dblcpm_pkg::SLOT_CH10];
      end
   end

   assign drop_bus_ch2_bits5_0 = drop_lo_r;
   assign drop_bus_ch2_bit6 = pin6_r;
   assign drop_bus_ch2_bit7 = pin7_r;
   assign line_data_out_ch6 = data6_r;
   assign line_data_out_ch10 = data10_r;

endmodule : dblcpm_top

/* File: dblcpm_checker.sv */
`timescale 1ns/1ps
module dblcpm_checker (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // register port and modes
   input wire dblcpm_pkg::dblcpm_up_req_t up_req,
   input wire dblcpm_pkg::dblcpm_up_rsp_t up_rsp,
   input wire logic tbus_ch2_enable,
   input wire logic sts1_mode_ch6,
   // outside clocks
   input wire logic drop_bus_ch2_clock,
   input wire logic line_rate_clock_ch6,
   input wire logic line_rate_clock_ch10,
   // pins
   input wire logic [5:0] drop_bus_ch2_bits5_0,
   input wire logic drop_bus_ch2_bit6,
   input wire logic drop_bus_ch2_bit7,
   input wire logic line_data_out_ch6
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // only ch6 invert is shadowed, to keep the helper small
   logic inv6_r;
   wire hit6 = up_req.indirect ? up_req.addr == 16'h7E01 : up_req.addr == 16'h7F01;
   wire hit10 = up_req.indirect ? up_req.addr == 16'hBE01 : up_req.addr == 16'hBF01;
   wire [7:0] pins = {drop_bus_ch2_bit7, drop_bus_ch2_bit6, drop_bus_ch2_bits5_0};
   always_ff @(posedge clock) begin
      if (!rstn) inv6_r <= 1'b0;
      else if (up_req.wr && hit6) inv6_r <= up_req.wdata[0];
   end
   // a half line period gives only seven stable samples, so the six-sample window fits with one to spare
   sequence s_idle6; (!tbus_ch2_enable && $stable(line_rate_clock_ch6)) [*6]; endsequence
   sequence s_idle10; (!tbus_ch2_enable && $stable(line_rate_clock_ch10)) [*6]; endsequence
   // mode must hold while the edge is filtered, or the update moment is undefined
   sequence s_fall6; $fell(line_rate_clock_ch6) ##0 (sts1_mode_ch6 || !inv6_r) [*5]; endsequence
   sequence s_rise6; $rose(line_rate_clock_ch6) ##0 (!sts1_mode_ch6 && inv6_r) [*5]; endsequence
   property p_ack; (up_req.wr || up_req.rd) |=> up_rsp.ack; endproperty
   a_ack: assert property (p_ack) else $error("access not acked");
   property p_ack_cause; up_rsp.ack |-> $past(up_req.wr || up_req.rd); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without access");
   property p_unmapped; up_req.rd && !hit6 && !hit10 |=> up_rsp.rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pin6; s_idle6 |-> drop_bus_ch2_bit6 == line_rate_clock_ch6; endproperty
   a_pin6: assert property (p_pin6) else $error("pin6 not ch6 clock");
   property p_pin7; s_idle10 |-> drop_bus_ch2_bit7 == line_rate_clock_ch10; endproperty
   a_pin7: assert property (p_pin7) else $error("pin7 not ch10 clock");
   property p_drop_hold;
      (tbus_ch2_enable && !drop_bus_ch2_clock) [*8] |-> $stable(pins);
   endproperty
   a_drop_hold: assert property (p_drop_hold)
      else $error("drop bus moved without rise");
   property p_no_fall_upd; s_fall6 |=> $stable(line_data_out_ch6) [*5]; endproperty
   a_no_fall_upd: assert property (p_no_fall_upd)
      else $error("ch6 data moved on fall");
   property p_no_rise_upd; s_rise6 |=> $stable(line_data_out_ch6) [*5]; endproperty
   a_no_rise_upd: assert property (p_no_rise_upd)
      else $error("ch6 data moved on rise");
endmodule : dblcpm_checker
bind dblcpm_top dblcpm_checker i_dblcpm_checker (.clock, .rstn, .up_req, .up_rsp,
   .tbus_ch2_enable, .sts1_mode_ch6, .drop_bus_ch2_clock, .line_rate_clock_ch6,
   .line_rate_clock_ch10, .drop_bus_ch2_bits5_0, .drop_bus_ch2_bit6, .drop_bus_ch2_bit7,
   .line_data_out_ch6);

/* File: dblcpm_liu.sv */
`timescale 1ns/1ps
module dblcpm_liu (
   // free-running line rate clocks, skewed so their edges never meet
   output logic line_rate_clock_ch6,
   output logic line_rate_clock_ch10,
   // serial bits, a new one with every clock edge
   output logic line_tx_bit_ch6,
   output logic line_tx_bit_ch10
);
   int c6;
   int c10;
   // period of three edges, so rise and fall samples differ often
   initial begin
      {line_rate_clock_ch6, line_rate_clock_ch10, line_tx_bit_ch6, line_tx_bit_ch10} = 4'h0;
      c6 = 0;
      c10 = 1;
      #3;
      forever begin
         #40;
         line_rate_clock_ch10 = ~line_rate_clock_ch10;
         c10 = (c10 == 2) ? 0 : c10 + 1;
         line_tx_bit_ch10 = (c10 == 0);
         #40;
         line_rate_clock_ch6 = ~line_rate_clock_ch6;
         c6 = (c6 == 2) ? 0 : c6 + 1;
         line_tx_bit_ch6 = (c6 == 0);
      end
   end
endmodule : dblcpm_liu

/* File: dblcpm_top_tb.sv */
`timescale 1ns/1ps
module dblcpm_top_tb;
   logic clock, rstn, tbus_ch2_enable, sts1_mode_ch6, sts1_mode_ch10;
   logic drop_word_valid, drop_bus_ch2_clock;
   logic [7:0] drop_word_data, rd_v;
   dblcpm_pkg::dblcpm_up_req_t up_req;
   dblcpm_pkg::dblcpm_up_rsp_t up_rsp;
   wire line_rate_clock_ch6, line_rate_clock_ch10, line_tx_bit_ch6, line_tx_bit_ch10;
   wire drop_word_ready, drop_bus_ch2_bit6, drop_bus_ch2_bit7;
   wire line_data_out_ch6, line_data_out_ch10;
   wire [5:0] drop_bus_ch2_bits5_0;
   wire [1:0] lclk = {line_rate_clock_ch10, line_rate_clock_ch6};
   wire [7:0] pins = {drop_bus_ch2_bit7, drop_bus_ch2_bit6, drop_bus_ch2_bits5_0};
   int n_fail, checks;
   dblcpm_top i_dblcpm_top (.clock, .rstn, .up_req, .up_rsp, .tbus_ch2_enable,
      .sts1_mode_ch6, .sts1_mode_ch10, .drop_word_data, .drop_word_valid, .drop_word_ready,
      .drop_bus_ch2_clock, .line_rate_clock_ch6, .line_rate_clock_ch10, .line_tx_bit_ch6,
      .line_tx_bit_ch10, .drop_bus_ch2_bits5_0, .drop_bus_ch2_bit6, .drop_bus_ch2_bit7,
      .line_data_out_ch6, .line_data_out_ch10);
   dblcpm_liu i_dblcpm_liu (.line_rate_clock_ch6, .line_rate_clock_ch10,
      .line_tx_bit_ch6, .line_tx_bit_ch10);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task report_and_stop;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task timed_out;
      check(8'h00, 8'h01);
      report_and_stop;
   endtask : timed_out
   // one register access; read data lands in rd_v
   task acc(input logic [15:0] a, input logic ind, input logic w, input logic [7:0] d);
      int i;
      @(negedge clock);
      up_req = '{addr: a, wdata: d, wr: w, rd: !w, indirect: ind};
      @(negedge clock);
      up_req.wr = 1'b0;
      up_req.rd = 1'b0;
      for (i = 0; i < 3 && up_rsp.ack !== 1'b1; i++) @(negedge clock);
      if (i == 3) timed_out;
      rd_v = up_rsp.rdata;
   endtask : acc
   task push(input logic [7:0] w);
      int i;
      @(negedge clock);
      drop_word_data = w;
      drop_word_valid = 1'b1;
      for (i = 0; i < 20 && drop_word_ready !== 1'b1; i++) @(negedge clock);
      if (i == 20) timed_out;
      @(negedge clock);
      drop_word_valid = 1'b0;
   endtask : push
   // one drop clock period; the clock stands low between words
   task dpulse(input logic [7:0] exp);
      @(negedge clock);
      drop_bus_ch2_clock = 1'b1;
      repeat (8) @(negedge clock);
      check(pins, exp);
      drop_bus_ch2_clock = 1'b0;
      repeat (8) @(negedge clock);
   endtask : dpulse
   task wait_lvl(input int ch, input logic v);
      int i;
      for (i = 0; i < 20 && lclk[ch] !== v; i++) @(posedge clock);
      if (i == 20) timed_out;
   endtask : wait_lvl
   task t_regs;
      acc(16'h7F01, 1'b0, 1'b0, 8'h00);
      check(rd_v & 8'h7F, 8'h00);
      acc(16'hBE01, 1'b1, 1'b0, 8'h00);
      check(rd_v & 8'h7F, 8'h00);
      acc(16'h7E01, 1'b1, 1'b1, 8'h5A);
      acc(16'h7F01, 1'b0, 1'b0, 8'h00);
      check(rd_v & 8'h7F, 8'h5A);
      acc(16'h1234, 1'b0, 1'b1, 8'hFF);
      acc(16'h1234, 1'b0, 1'b0, 8'h00);
      check(rd_v, 8'h00);
   endtask : t_regs
   task t_drop;
      tbus_ch2_enable = 1'b1;
      push(8'h80);
      push(8'h41);
      check({7'h00, drop_word_ready}, 8'h00);
      check(pins, 8'h00);
      dpulse(8'h80);
      push(8'hC2);
      dpulse(8'h41);
      dpulse(8'hC2);
      dpulse(8'hC2);
      tbus_ch2_enable = 1'b0;
   endtask : t_drop
   // ch10 is written indirect and read direct, ch6 the other way round
   task t_line(input int ch, input logic sts, input logic inv);
      logic lvl, b, o;
      acc(ch ? 16'hBE01 : 16'h7F01, ch[0], 1'b1, {7'h00, inv});
      acc(ch ? 16'hBF01 : 16'h7E01, !ch[0], 1'b0, 8'h00);
      check(rd_v & 8'h7F, {7'h00, inv});
      sts1_mode_ch6 = sts;
      sts1_mode_ch10 = sts;
      lvl = !(inv && !sts);
      repeat (3) begin
         wait_lvl(ch, !lvl);
         wait_lvl(ch, lvl);
         b = ch ? line_tx_bit_ch10 : line_tx_bit_ch6;
         repeat (7) @(posedge clock);
         @(negedge clock);
         o = ch ? line_data_out_ch10 : line_data_out_ch6;
         check({7'h00, o}, {7'h00, b});
      end
   endtask : t_line
   initial begin
      {rstn, tbus_ch2_enable, sts1_mode_ch6, sts1_mode_ch10} = 4'h0;
      {drop_word_valid, drop_bus_ch2_clock, drop_word_data} = 10'h000;
      up_req = '0;
      n_fail = 0;
      checks = 0;
      repeat (20) @(negedge clock);
      rstn = 1'b1;
      t_regs;
      t_drop;
      for (int ch = 0; ch < 2; ch++) begin
         for (int m = 0; m < 3; m++) t_line(ch, m == 2, m != 0);
      end
      report_and_stop;
   end
endmodule : dblcpm_top_tb
